//--- lfmon_pkg.sv
// Shared constants for the linefeed state and loop monitor block
package lfmon_pkg;

   // ****************************************
   // Register offsets on the serial port
   // ****************************************
   localparam logic [6:0] OFS_LINE_STATE = 7'h40;
   localparam logic [6:0] OFS_LOOP_V     = 7'h4E;
   localparam logic [6:0] OFS_LOOP_I     = 7'h4F;
   localparam logic [6:0] OFS_TIP_V      = 7'h50;
   localparam logic [6:0] OFS_RING_V     = 7'h51;
   localparam logic [6:0] OFS_BAT1_V     = 7'h52;
   localparam logic [6:0] OFS_BAT2_V     = 7'h53;
   localparam logic [6:0] OFS_CUR1       = 7'h54;
   localparam logic [6:0] OFS_CUR2       = 7'h55;
   localparam logic [6:0] OFS_CUR3       = 7'h56;
   localparam logic [6:0] OFS_CUR4       = 7'h57;
   localparam logic [6:0] OFS_CUR5       = 7'h58;
   localparam logic [6:0] OFS_CUR6       = 7'h59;
   localparam int         MEAS_COUNT     = 12;

   // ****************************************
   // Line state field codes and reset value
   // ****************************************
   localparam logic [2:0] LS_OPEN      = 3'h0;
   localparam logic [2:0] LS_FWD_ACT   = 3'h1;
   localparam logic [2:0] LS_FWD_OHT   = 3'h2;
   localparam logic [2:0] LS_TIP_OPEN  = 3'h3;
   localparam logic [2:0] LS_RINGING   = 3'h4;
   localparam logic [2:0] LS_REV_ACT   = 3'h5;
   localparam logic [2:0] LS_REV_OHT   = 3'h6;
   localparam logic [2:0] LS_RING_OPEN = 3'h7;
   localparam logic [2:0] LS_RESET     = LS_OPEN;

   // ****************************************
   // Sign-magnitude field layout
   // ****************************************
   localparam int SIGN_BIT = 7;
   localparam int MAG_MAX  = 63;

   // ****************************************
   // Measurement scaling (mV and uA per step)
   // ****************************************
   localparam int LEAD_STEP_MV   = 376;
   localparam int LOOP_V_STEP_MV = 1500;
   localparam int IQ12_STEP_UA   = 319;
   localparam int IQ56_STEP_UA   = 316;
   localparam int LOOP_I_STEP_UA = 1270;
   localparam int SCALE_SHIFT    = 16;
   localparam int K_LOOP_V = ((1 << SCALE_SHIFT) * LEAD_STEP_MV + LOOP_V_STEP_MV / 2)
                             / LOOP_V_STEP_MV;
   localparam int K_LOOP_I = ((1 << SCALE_SHIFT) + LOOP_I_STEP_UA / 2) / LOOP_I_STEP_UA;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_HZ        = 250_000_000;
   localparam int SAMPLE_HZ     = 800;
   localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_HZ;
   localparam int SPI_FRAME     = 16;
   localparam int SPI_ADDR_BITS = 8;

endpackage

//--- lfmon_meas_mem.sv
// Measurement sample store with registered read data
`timescale 1ns/1ps
module lfmon_meas_mem #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 12
) (
   input  wire logic                     clk_sys,
   input  wire logic                     srst,
   input  wire logic                     we,
   input  wire logic [$clog2(DEPTH)-1:0] wrAddr,
   input  wire logic [WIDTH-1:0]         wrData,
   input  wire logic [$clog2(DEPTH)-1:0] rdAddr,
   output logic      [WIDTH-1:0]         rdData
);
   import lfmon_pkg::*;

   if (DEPTH < 2 || WIDTH < 1) begin : g_chk
      $error("lfmon_meas_mem: DEPTH must be at least 2");
   end

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [WIDTH-1:0]            rdData;
   } lfmon_mem_t;

   lfmon_mem_t st;
   lfmon_mem_t next_st;

   // Write port from capture, read port from the serial side
   always_comb
   begin
      next_st = st;
      if (we && 32'(wrAddr) < DEPTH)
      begin
         next_st.mem[wrAddr] = wrData;
      end
      // Out-of-range index reads zero rather than an undefined row
      next_st.rdData = (32'(rdAddr) < DEPTH) ? st.mem[rdAddr] : '0;
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign rdData = st.rdData;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   chk_read_latest: assert property (
      (32'($past(rdAddr)) < DEPTH) |-> rdData == $past(st.mem[rdAddr]))
      else $error("read data is not the stored sample");
endmodule

//--- lfmon_spi_slave.sv
// Serial control port slave: address byte then data byte
`timescale 1ns/1ps
module lfmon_spi_slave (
   input  wire logic       clk_sys,
   input  wire logic       srst,
   input  wire logic       spiClk,
   input  wire logic       spiCsN,
   input  wire logic       spiMosi,
   output logic            spiMiso,
   output logic            spiMisoEnN,
   output logic [6:0]      regAddr,
   output logic [7:0]      wrData,
   output logic            wrStrobe,
   input  wire logic [7:0] rdData
);
   import lfmon_pkg::*;

   typedef struct packed {
      logic       clk1, clk2, clk3;
      logic       cs1, cs2;
      logic       mosi1, mosi2;
      logic [4:0] bitCnt;
      logic [7:0] shiftIn;
      logic [7:0] shiftOut;
      logic       isRead;
      logic       miso, misoEnN;
      logic [6:0] addr;
      logic [7:0] wdata;
      logic       wrStb;
   } lfmon_spi_t;

   lfmon_spi_t st;
   lfmon_spi_t next_st;
   logic       rise;
   logic       fall;

   // Edges come from the second stage and its delayed copy only
   assign rise = st.clk2 && !st.clk3;
   assign fall = !st.clk2 && st.clk3;

   // Mode 0, MSB first; first byte is read flag plus address
   always_comb
   begin
      next_st       = st;
      next_st.clk1  = spiClk;
      next_st.clk2  = st.clk1;
      next_st.clk3  = st.clk2;
      next_st.cs1   = spiCsN;
      next_st.cs2   = st.cs1;
      next_st.mosi1 = spiMosi;
      next_st.mosi2 = st.mosi1;
      next_st.wrStb = 1'b0;
      if (st.cs2)
      begin
         next_st.bitCnt  = '0;
         next_st.misoEnN = 1'b1;
         next_st.miso    = 1'b0;
      end
      else if (rise && st.bitCnt < 5'(SPI_FRAME))
      begin
         next_st.shiftIn = {st.shiftIn[6:0], st.mosi2};
         next_st.bitCnt  = st.bitCnt + 5'h01;
         if (st.bitCnt == 5'(SPI_ADDR_BITS - 1))
         begin
            next_st.isRead = st.shiftIn[6];
            next_st.addr   = {st.shiftIn[5:0], st.mosi2};
         end
         // Frame end: only a write frame commits
         if (st.bitCnt == 5'(SPI_FRAME - 1) && !st.isRead)
         begin
            next_st.wdata = {st.shiftIn[6:0], st.mosi2};
            next_st.wrStb = 1'b1;
         end
      end
      else if (fall && st.isRead && st.bitCnt >= 5'(SPI_ADDR_BITS)
               && st.bitCnt < 5'(SPI_FRAME))
      begin
         // Fresh read data is taken on the first falling edge of the data byte
         if (st.bitCnt == 5'(SPI_ADDR_BITS))
         begin
            next_st.miso     = rdData[7];
            next_st.shiftOut = {rdData[6:0], 1'b0};
         end
         else
         begin
            next_st.miso     = st.shiftOut[7];
            next_st.shiftOut = {st.shiftOut[6:0], 1'b0};
         end
         next_st.misoEnN = 1'b0;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         st         <= '0;
         st.clk1    <= 1'b0;
         st.cs1     <= 1'b1;
         st.cs2     <= 1'b1;
         st.misoEnN <= 1'b1;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign spiMiso    = st.miso;
   assign spiMisoEnN = st.misoEnN;
   assign regAddr    = st.addr;
   assign wrData     = st.wdata;
   assign wrStrobe   = st.wrStb;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   chk_release_miso: assert property (
      st.cs2 |=> spiMisoEnN && !wrStrobe)
      else $error("miso driven while deselected");
   chk_write_pulse: assert property (
      wrStrobe |-> $past(st.bitCnt) == 5'(SPI_FRAME - 1) && !st.isRead ##1 !wrStrobe)
      else $error("write strobe not a single end-of-frame pulse");
endmodule

//--- lfmon_top.sv
// Linefeed state selector and loop measurement readout
`timescale 1ns/1ps
module lfmon_top #(
   parameter int SAMPLE_CYCLES = lfmon_pkg::SAMPLE_CYCLES
) (
   input  wire logic       clk_sys,
   input  wire logic       srst,
   input  wire logic       spiClk,
   input  wire logic       spiCsN,
   input  wire logic       spiMosi,
   output logic            spiMiso,
   output logic            spiMisoEnN,
   input  wire logic [7:0] adcTip,
   input  wire logic [7:0] adcRing,
   input  wire logic [7:0] adcBat1,
   input  wire logic [7:0] adcBat2,
   input  wire logic [7:0] adcCur1,
   input  wire logic [7:0] adcCur2,
   input  wire logic [7:0] adcCur3,
   input  wire logic [7:0] adcCur4,
   input  wire logic [7:0] adcCur5,
   input  wire logic [7:0] adcCur6,
   input  wire logic       powerAlarm,
   input  wire logic       autoOpenEnable,
   output logic            tipDriveOn,
   output logic            ringDriveOn,
   output logic            polarityReverse,
   output logic            audioPathOn,
   output logic            ringingOn,
   output logic            sampleTick
);
   import lfmon_pkg::*;

   localparam int CNT_W = $clog2(SAMPLE_CYCLES);

   // Capture walks twelve rows, so the period must leave room for it
   if (SAMPLE_CYCLES < 4 * MEAS_COUNT) begin : g_chk
      $error("lfmon_top: SAMPLE_CYCLES too small");
   end

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic [2:0]       lineState;
      logic             tipDrive;
      logic             ringDrive;
      logic             reversed;
      logic             audio;
      logic             ringing;
      logic [CNT_W-1:0] tickCnt;
      logic             tick;
      logic             capBusy;
      logic [3:0]       capIdx;
      logic [7:0]       rdData;
   } lfmon_top_t;

   lfmon_top_t st;
   lfmon_top_t next_st;

   logic [6:0] regAddr;
   logic [7:0] wrData;
   logic       wrStrobe;
   logic [7:0] memRdData;
   logic [3:0] memRdIdx;
   logic       inMeas;
   logic [7:0] capData;
   logic [7:0] loopVolt;
   logic [7:0] loopCurr;
   logic       alarmOpen;

   // ****************************************
   // Helpers
   // ****************************************
   // Scale a magnitude by a 16-bit fraction and clip to the field
   function automatic logic [5:0] lfmon_scale(input logic [19:0] mag, input logic [15:0] k);
      logic [35:0] prod;
      prod = 36'(mag) * 36'(k);
      return (prod[35:SCALE_SHIFT] > 20'(MAG_MAX)) ? 6'(MAG_MAX) : prod[SCALE_SHIFT+5:SCALE_SHIFT];
   endfunction

   // Pack sign and magnitude; a zero result never carries a sign
   function automatic logic [7:0] lfmon_signmag(input logic neg, input logic [5:0] mag);
      return {neg && (mag != 6'h00), 1'b0, mag};
   endfunction

   // ****************************************
   // Serial port and sample store
   // ****************************************
   lfmon_spi_slave u_spi (
      .clk_sys    (clk_sys),
      .srst       (srst),
      .spiClk     (spiClk),
      .spiCsN     (spiCsN),
      .spiMosi    (spiMosi),
      .spiMiso    (spiMiso),
      .spiMisoEnN (spiMisoEnN),
      .regAddr    (regAddr),
      .wrData     (wrData),
      .wrStrobe   (wrStrobe),
      .rdData     (st.rdData)
   );

   lfmon_meas_mem #(
      .WIDTH (8),
      .DEPTH (MEAS_COUNT)
   ) u_mem (
      .clk_sys (clk_sys),
      .srst    (srst),
      .we      (st.capBusy),
      .wrAddr  (st.capIdx),
      .wrData  (capData),
      .rdAddr  (memRdIdx),
      .rdData  (memRdData)
   );

   // Measurement window decode for reads
   assign inMeas   = (regAddr >= OFS_LOOP_V) && (regAddr <= OFS_CUR6);
   assign memRdIdx = 4'(regAddr - OFS_LOOP_V);

   // ****************************************
   // Derived loop values
   // ****************************************
   // Loop voltage from lead readings, which are magnitudes of negative voltages
   always_comb
   begin
      logic signed [9:0] dv;
      logic [9:0]        av;
      dv = '0;
      av = '0;
      if (st.lineState == LS_TIP_OPEN)
      begin
         dv = -$signed({2'b00, adcRing});
      end
      else
      begin
         dv = $signed({2'b00, adcRing}) - $signed({2'b00, adcTip});
      end
      av = dv[9] ? 10'(-dv) : 10'(dv);
      loopVolt = lfmon_signmag(dv[9], lfmon_scale(20'(av), 16'(K_LOOP_V)));
   end

   // Loop current in uA from the outer transistor pairs
   always_comb
   begin
      logic signed [9:0]  d12;
      logic signed [9:0]  d56;
      logic signed [19:0] isum;
      logic [19:0]        ai;
      d12  = $signed({2'b00, adcCur1}) - $signed({2'b00, adcCur2});
      d56  = $signed({2'b00, adcCur5}) - $signed({2'b00, adcCur6});
      isum = 20'(d12 * IQ12_STEP_UA) + 20'(d56 * IQ56_STEP_UA);
      // One lead carries the whole current when the other is open
      if (st.lineState != LS_TIP_OPEN && st.lineState != LS_RING_OPEN)
      begin
         isum = isum >>> 1;
      end
      ai = isum[19] ? 20'(-isum) : 20'(isum);
      loopCurr = lfmon_signmag(isum[19], lfmon_scale(ai, 16'(K_LOOP_I)));
   end

   // Row written by the capture walk; raw readings stored unchanged
   always_comb
   begin
      case (st.capIdx)
         4'h0:    capData = loopVolt;
         4'h1:    capData = loopCurr;
         4'h2:    capData = adcTip;
         4'h3:    capData = adcRing;
         4'h4:    capData = adcBat1;
         4'h5:    capData = adcBat2;
         4'h6:    capData = adcCur1;
         4'h7:    capData = adcCur2;
         4'h8:    capData = adcCur3;
         4'h9:    capData = adcCur4;
         4'hA:    capData = adcCur5;
         4'hB:    capData = adcCur6;
         default: capData = 8'h00;
      endcase
   end

   // ****************************************
   // Next state
   // ****************************************
   assign alarmOpen = powerAlarm && autoOpenEnable;

   always_comb
   begin
      next_st      = st;
      next_st.tick = 1'b0;
      // Host write; measurement rows take no host writes
      if (wrStrobe && regAddr == OFS_LINE_STATE)
      begin
         next_st.lineState = wrData[2:0];
      end
      // Protection wins over a host write in the same cycle
      if (alarmOpen)
      begin
         next_st.lineState = LS_OPEN;
      end
      next_st.tipDrive  = 1'b1;
      next_st.ringDrive = 1'b1;
      next_st.reversed  = 1'b0;
      next_st.audio     = 1'b0;
      next_st.ringing   = 1'b0;
      case (next_st.lineState)
         LS_OPEN:
         begin
            next_st.tipDrive  = 1'b0;
            next_st.ringDrive = 1'b0;
         end
         LS_FWD_ACT:   next_st.audio    = 1'b0;
         LS_FWD_OHT:   next_st.audio    = 1'b1;
         LS_TIP_OPEN:  next_st.tipDrive = 1'b0;
         LS_RINGING:   next_st.ringing  = 1'b1;
         LS_REV_ACT:   next_st.reversed = 1'b1;
         LS_REV_OHT:
         begin
            next_st.reversed = 1'b1;
            next_st.audio    = 1'b1;
         end
         LS_RING_OPEN: next_st.ringDrive = 1'b0;
         default:      next_st.tipDrive  = 1'b0;
      endcase
      // Free-running sample period
      if (st.tickCnt == '0)
      begin
         next_st.tickCnt = CNT_W'(SAMPLE_CYCLES - 1);
         next_st.tick    = 1'b1;
      end
      else
      begin
         next_st.tickCnt = st.tickCnt - 1'b1;
      end
      // Capture walk, one row per cycle
      if (st.tick)
      begin
         next_st.capBusy = 1'b1;
         next_st.capIdx  = 4'h0;
      end
      else if (st.capBusy)
      begin
         next_st.capBusy = (st.capIdx != 4'(MEAS_COUNT - 1));
         next_st.capIdx  = (st.capIdx == 4'(MEAS_COUNT - 1)) ? 4'h0 : st.capIdx + 4'h1;
      end
      // Read mux; unmapped addresses and reserved bits read zero
      if (regAddr == OFS_LINE_STATE)
      begin
         next_st.rdData = {5'h00, st.lineState};
      end
      else
      begin
         next_st.rdData = inMeas ? memRdData : 8'h00;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         st           <= '0;
         st.lineState <= LS_RESET;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign tipDriveOn      = st.tipDrive;
   assign ringDriveOn     = st.ringDrive;
   assign polarityReverse = st.reversed;
   assign audioPathOn     = st.audio;
   assign ringingOn       = st.ringing;
   assign sampleTick      = st.tick;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   sequence seq_capStart;
      st.capBusy && st.capIdx == 4'h0;
   endsequence
   sequence seq_capEnd;
      st.capBusy && st.capIdx == 4'hB ##1 !st.capBusy;
   endsequence

   chk_state_write: assert property (
      wrStrobe && regAddr == OFS_LINE_STATE && !alarmOpen |=> st.lineState == $past(wrData[2:0]))
      else $error("line state write lost");
   chk_open_drives_off: assert property (
      st.lineState == LS_OPEN |-> !tipDriveOn && !ringDriveOn && !audioPathOn && !ringingOn)
      else $error("drive on in open state");
   chk_alarm_opens: assert property (
      alarmOpen |=> st.lineState == LS_OPEN && !tipDriveOn && !ringDriveOn)
      else $error("power alarm did not open line");
   chk_active_audio_off: assert property (
      st.lineState == LS_FWD_ACT || st.lineState == LS_REV_ACT |->
      tipDriveOn && ringDriveOn && !audioPathOn
      && polarityReverse == (st.lineState == LS_REV_ACT))
      else $error("active state outputs wrong");
   chk_oht_audio_on: assert property (
      st.lineState == LS_FWD_OHT || st.lineState == LS_REV_OHT |->
      audioPathOn && tipDriveOn && ringDriveOn)
      else $error("audio off in on-hook transmission");
   chk_tip_open: assert property (
      st.lineState == LS_TIP_OPEN |-> !tipDriveOn && ringDriveOn)
      else $error("tip open drives wrong");
   chk_ring_open: assert property (
      st.lineState == LS_RING_OPEN |-> tipDriveOn && !ringDriveOn)
      else $error("ring open drives wrong");
   chk_ringing_on: assert property (
      ringingOn |-> st.lineState == LS_RINGING && !audioPathOn)
      else $error("ringing outside ringing state");
   chk_capture_walk: assert property (
      sampleTick |=> seq_capStart ##11 seq_capEnd)
      else $error("capture walk broken");
   chk_tick_spacing: assert property (
      sampleTick |-> $past(st.tickCnt) == '0 ##1 st.tickCnt == CNT_W'(SAMPLE_CYCLES - 2))
      else $error("sample period wrong");
   chk_ground_start_v: assert property (
      st.lineState == LS_TIP_OPEN && adcRing >= 8'h08 |-> loopVolt[SIGN_BIT])
      else $error("ground start loop voltage not negative");
   chk_loop_i_zero: assert property (
      adcCur1 == adcCur2 && adcCur5 == adcCur6 |-> loopCurr == 8'h00)
      else $error("balanced currents give nonzero loop current");
endmodule

//--- lfmon_line_model.sv
// Line side model: converter readings of leads, battery and transistors
`timescale 1ns/1ps
module lfmon_line_model (
   input  wire logic        clk_sys,
   input  wire logic [79:0] setVal,
   output logic      [79:0] adcVal
);
   // ****************************************
   // Readings
   // ****************************************
   // Known value at time zero, so no unknown reaches the sampler
   initial adcVal = 80'h0;

   // Readings move only on a clock edge, like a converter output
   always @(posedge clk_sys)
   begin
      adcVal <= setVal;
   end
endmodule

//--- lfmon_top_tb.sv
// Self-checking bench of the linefeed state and loop monitor
`timescale 1ns/1ps
module lfmon_top_tb;
   import lfmon_pkg::*;
   localparam int SC = 64;
   logic        clk_sys = 1'h0;
   logic        srst = 1'h1;
   logic        spiClk = 1'h0;
   logic        spiCsN = 1'h1;
   logic        spiMosi = 1'h0;
   logic        powerAlarm = 1'h0;
   logic        autoOpenEnable = 1'h0;
   logic        spiMiso, spiMisoEnN, sampleTick;
   wire  [4:0]  outs;
   logic        enSeen;
   logic [79:0] setVal = 80'h0;
   logic [79:0] adcVal;
   logic [7:0]  rd;
   int          n_errors = 0;
   int          comparisons = 0;
   int          seed = 65420;
   int          cyc = 0;
   int          last = 0;
   int          period = 0;

   // ****************************************
   // Clock, instances, watchdog
   // ****************************************
   always #2 clk_sys = ~clk_sys;

   lfmon_line_model i_lfmon_line_model (.clk_sys(clk_sys), .setVal(setVal), .adcVal(adcVal));

   lfmon_top #(.SAMPLE_CYCLES(SC)) i_lfmon_top (
      .clk_sys(clk_sys), .srst(srst), .spiClk(spiClk), .spiCsN(spiCsN),
      .spiMosi(spiMosi), .spiMiso(spiMiso), .spiMisoEnN(spiMisoEnN),
      .adcTip(adcVal[7:0]), .adcRing(adcVal[15:8]), .adcBat1(adcVal[23:16]),
      .adcBat2(adcVal[31:24]), .adcCur1(adcVal[39:32]), .adcCur2(adcVal[47:40]),
      .adcCur3(adcVal[55:48]), .adcCur4(adcVal[63:56]), .adcCur5(adcVal[71:64]),
      .adcCur6(adcVal[79:72]), .powerAlarm(powerAlarm), .autoOpenEnable(autoOpenEnable),
      .tipDriveOn(outs[4]), .ringDriveOn(outs[3]), .polarityReverse(outs[2]),
      .audioPathOn(outs[1]), .ringingOn(outs[0]), .sampleTick(sampleTick));

   // Tick spacing and hang guard; a run needs about 20000 cycles
   always @(posedge clk_sys)
   begin
      cyc <= cyc + 1;
      if (sampleTick === 1'h1)
      begin
         period <= cyc - last;
         last <= cyc;
      end
      if (cyc == 40000)
      begin
         n_errors++;
         results();
      end
   end

   // ****************************************
   // Tasks and expectations
   // ****************************************
   task automatic waitc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One frame: command byte then data byte, slow clock of 16 cycles
   task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd);
      logic [15:0] sh;
      sh = {cmd, wd};
      spiCsN <= 1'h0;
      waitc(8);
      for (int i = 15; i >= 0; i--)
      begin
         spiMosi <= sh[i];
         waitc(8);
         spiClk <= 1'h1;
         rd[i % 8] = spiMiso;
         if (i == 0)
            enSeen = spiMisoEnN;
         waitc(8);
         spiClk <= 1'h0;
      end
      waitc(8);
      spiCsN <= 1'h1;
      waitc(8);
   endtask

   // Expected drives {tip, ring, reverse, audio, ringing} per state
   function automatic logic [4:0] dec(input logic [2:0] s);
      logic [4:0] t [8] = '{5'h00, 5'h18, 5'h1A, 5'h08, 5'h19, 5'h1C, 5'h1E, 5'h10};
      return t[s];
   endfunction

   // Sign-magnitude packing; a zero magnitude is never signed
   function automatic logic [7:0] sm(input int x, input int k);
      int m;
      m = ((x < 0 ? -x : x) * k) >> SCALE_SHIFT;
      if (m > MAG_MAX) m = MAG_MAX;
      return {(x < 0 && m != 0), 1'h0, 6'(m)};
   endfunction

   function automatic logic [7:0] expMeas(input int a, input logic [2:0] s, input logic [79:0] v);
      int d;
      if (a == 0)
         return sm((s == LS_TIP_OPEN) ? -int'(v[15:8]) : int'(v[15:8]) - int'(v[7:0]), K_LOOP_V);
      if (a > 1)
         return v[8*(a-2)+:8];
      d = (int'(v[39:32]) - int'(v[47:40])) * IQ12_STEP_UA
        + (int'(v[71:64]) - int'(v[79:72])) * IQ56_STEP_UA;
      if (s != LS_TIP_OPEN && s != LS_RING_OPEN) d = d >>> 1;
      return sm(d, K_LOOP_I);
   endfunction

   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   initial
   begin
      logic [2:0] ms [3] = '{LS_FWD_ACT, LS_TIP_OPEN, LS_RING_OPEN};
      waitc(6);
      check("drives in reset", {3'h0, outs}, 8'h00);
      check("miso released", {7'h0, spiMisoEnN}, 8'h01);
      srst <= 1'h0;
      waitc(4);
      // Every state, upper bits set, descending so each write changes state
      for (int s = 7; s >= 0; s--)
      begin
         xfer({1'h0, OFS_LINE_STATE}, {5'h1F, 3'(s)});
         waitc(8);
         if (s < 4)
            check("drives", 8'(outs), 8'(dec(3'(s))));
         else
            check("drives", 8'(outs), 8'(dec(3'(s))));
         xfer({1'h1, OFS_LINE_STATE}, 8'h00);
         check("state readback", rd, 8'(s));
         check("miso enable", {7'h0, enSeen}, 8'h00);
      end
      $display("test line states done");
      // Clipping corner first, then random readings
      for (int k = 0; k < 3; k++)
      begin
         setVal <= (k == 0) ? 80'h00FF_0000_00FF_0000_00FF
                            : 80'({$random(seed), $random(seed), $random(seed)});
         xfer({1'h0, OFS_LINE_STATE}, {5'h0, ms[k]});
         xfer({1'h0, OFS_TIP_V}, 8'h5A);
         // A write to a reading must not alias onto the state register
         xfer({1'h1, OFS_LINE_STATE}, 8'h00);
         check("state kept", rd, {5'h0, ms[k]});
         waitc(3 * SC);
         for (int a = 0; a < MEAS_COUNT; a++)
         begin
            xfer({1'h1, 7'(OFS_LOOP_V + a)}, 8'h00);
            if (a == 0)
               check("loop voltage", rd, expMeas(a, ms[k], setVal));
            else if (a == 1)
               check("loop current", rd, expMeas(a, ms[k], setVal));
            else
               check("reading", rd, expMeas(a, ms[k], setVal));
         end
      end
      check("sample period", 8'(period), 8'(SC));
      xfer({1'h1, 7'h20}, 8'h00);
      check("unmapped read", rd, 8'h00);
      $display("test measurements done");
      // Alarm ignored while auto open is off, then forces open
      xfer({1'h0, OFS_LINE_STATE}, 8'h01);
      powerAlarm <= 1'h1;
      waitc(4);
      check("alarm gated", {3'h0, outs}, 8'h18);
      autoOpenEnable <= 1'h1;
      waitc(3);
      check("alarm open", {3'h0, outs}, 8'h00);
      powerAlarm <= 1'h0;
      xfer({1'h1, OFS_LINE_STATE}, 8'h00);
      check("alarm state", rd, 8'h00);
      $display("test power alarm done");
      results();
   end
endmodule
